// *** inc/cmmd_pkg.sv ***
`default_nettype none
package cmmd_pkg;
    // data space segment bounds
    localparam logic [15:0] CMMD_RAM_BASE = 16'h0000;
    localparam logic [15:0] CMMD_RAM_TOP = 16'h7FFF;
    localparam logic [15:0] CMMD_REG_BASE = 16'h8000;
    localparam logic [15:0] CMMD_REG_TOP = 16'hBFFF;
    localparam logic [15:0] CMMD_CMEM_BASE = 16'hC000;
    localparam logic [15:0] CMMD_CMEM_TOP = 16'hF3FF;
    // program store: two 64 kByte pages
    localparam int CMMD_PAGE_BITS = 1;
    localparam logic [7:0] CMMD_RDATA_RST = 8'h00;
    localparam logic CMMD_PAGE_RST = 1'b0;

    typedef enum logic [1:0] {
        CMMD_TGT_RAM,
        CMMD_TGT_REG,
        CMMD_TGT_CMEM,
        CMMD_TGT_NONE
    } cmmd_tgt_e;

    function automatic cmmd_tgt_e cmmd_decode(input logic [15:0] a);
        if (a <= CMMD_RAM_TOP) begin
            cmmd_decode = CMMD_TGT_RAM;
        end else if (a >= CMMD_REG_BASE && a <= CMMD_REG_TOP) begin
            cmmd_decode = CMMD_TGT_REG;
        end else if (a >= CMMD_CMEM_BASE && a <= CMMD_CMEM_TOP) begin
            cmmd_decode = CMMD_TGT_CMEM;
        end else begin
            cmmd_decode = CMMD_TGT_NONE;
        end
    endfunction
endpackage
`default_nettype wire

// *** src/cmmd_rdmux.sv ***
`timescale 1ns/100ps
`default_nettype none
module cmmd_rdmux
    import cmmd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // selection
    input wire logic rd_en,
    input wire cmmd_tgt_e tgt,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] cmem_rdata,
    // result
    output logic [7:0] rdata
);
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (rd_en) begin
            case (tgt)
                CMMD_TGT_RAM: rdata_next = ram_rdata;
                CMMD_TGT_REG: rdata_next = reg_rdata;
                CMMD_TGT_CMEM: rdata_next = cmem_rdata;
                default: rdata_next = CMMD_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= CMMD_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// *** src/cmmd_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module cmmd_decoder
    import cmmd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // program fetch side
    input wire logic prog_rd,
    input wire logic [15:0] prog_addr,
    input wire logic prog_page,
    output logic prog_mem_rd,
    output logic [16:0] prog_mem_addr,
    // processor data side
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata,
    // data RAM
    output logic ram_sel,
    output logic ram_wr,
    input wire logic [7:0] ram_rdata,
    // register bank
    output logic reg_sel,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata,
    // common memory
    output logic cmem_sel,
    output logic cmem_wr,
    input wire logic [7:0] cmem_rdata,
    // shared address and write data
    output logic [15:0] tgt_addr,
    output logic [7:0] tgt_wdata
);
    ////////////////////////////////////////////////////////////////////
    // nrst is a pin: two flops keep its release clear of the edge
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    ////////////////////////////////////////////////////////////////////
    // program side: page bit becomes address bit 16
    // page source is outside this block; it is taken as given
    assign prog_mem_rd = prog_rd;
    assign prog_mem_addr = {prog_page, prog_addr};

    ////////////////////////////////////////////////////////////////////
    // data side is combinational so the targets see the cycle's request
    cmmd_tgt_e tgt;
    logic acc;

    assign tgt = cmmd_decode(data_addr);
    assign acc = data_rd | data_wr;
    // only the three segments exist here; buffers have no address
    assign ram_sel = acc && (tgt == CMMD_TGT_RAM);
    assign reg_sel = acc && (tgt == CMMD_TGT_REG);
    assign cmem_sel = acc && (tgt == CMMD_TGT_CMEM);
    // reserved range: no select, so no write reaches anything
    assign ram_wr = ram_sel & data_wr;
    assign reg_wr = reg_sel & data_wr;
    assign cmem_wr = cmem_sel & data_wr;
    assign tgt_addr = data_addr;
    assign tgt_wdata = data_wdata;

    ////////////////////////////////////////////////////////////////////
    // targets answer one cycle after select; data captured then
    logic rd_pend_reg;
    logic rd_pend_next;
    cmmd_tgt_e tgt_reg;
    cmmd_tgt_e tgt_next;

    always_comb begin
        rd_pend_next = data_rd;
        tgt_next = tgt;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_reg <= 1'b0;
            tgt_reg <= CMMD_TGT_NONE;
        end else begin
            rd_pend_reg <= rd_pend_next;
            tgt_reg <= tgt_next;
        end
    end

    cmmd_rdmux u_rdmux (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rd_en(rd_pend_reg),
        .tgt(tgt_reg),
        .ram_rdata(ram_rdata),
        .reg_rdata(reg_rdata),
        .cmem_rdata(cmem_rdata),
        .rdata(data_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // segment bounds, both directions, against the package limits except a_reg_range, which tests data_addr[15:14]
    a_ram_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ram_sel |-> data_addr <= CMMD_RAM_TOP)
        else $error("ram selected outside its range");

    a_ram_cover: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && data_addr <= CMMD_RAM_TOP) |-> ram_sel)
        else $error("ram not selected inside its range");

    a_reg_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && data_addr[15:14] == 2'h2) |-> reg_sel)
        else $error("register bank not selected");

    a_reg_bound: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        reg_sel |->
        (data_addr >= CMMD_REG_BASE && data_addr <= CMMD_REG_TOP))
        else $error("register bank selected outside its range");

    a_cmem_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && data_addr >= CMMD_CMEM_BASE && data_addr <= CMMD_CMEM_TOP)
        |-> (cmem_sel && !ram_sel && !reg_sel))
        else $error("common memory not selected");

    a_cmem_bound: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cmem_sel |->
        (data_addr >= CMMD_CMEM_BASE && data_addr <= CMMD_CMEM_TOP))
        else $error("common memory selected outside its range");

    // at most one target, and none unless the processor asks
    a_one_select: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $onehot0({ram_sel, reg_sel, cmem_sel}))
        else $error("more than one target selected");

    a_idle_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !acc |-> !(ram_sel || reg_sel || cmem_sel))
        else $error("target selected with no access");

    a_wr_strobe: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ram_wr || reg_wr || cmem_wr) |-> data_wr)
        else $error("target write strobe with no write");

    a_resv_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (data_addr > CMMD_CMEM_TOP) |->
        !(ram_sel || reg_sel || cmem_sel || ram_wr || reg_wr || cmem_wr))
        else $error("reserved address selected a target");

    // read data lands two edges after the request and then stands
    a_resv_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (data_rd && data_addr > CMMD_CMEM_TOP) |-> ##2 data_rdata == 8'h00)
        else $error("reserved read did not return zero");

    a_ram_data: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (data_rd && ram_sel) ##1 1'b1 |=> data_rdata == $past(ram_rdata))
        else $error("ram read data not returned");

    a_reg_data: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (data_rd && reg_sel) ##1 1'b1 |=> data_rdata == $past(reg_rdata))
        else $error("register read data not returned");

    a_cmem_data: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (data_rd && cmem_sel) ##1 1'b1 |=> data_rdata == $past(cmem_rdata))
        else $error("common memory read data not returned");

    a_rd_pend: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        data_rd |=> (rd_pend_reg && tgt_reg == $past(tgt)))
        else $error("read not captured for the answer cycle");

    a_rd_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !data_rd |=> !rd_pend_reg)
        else $error("read pending with no read request");

    a_rd_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !rd_pend_reg |=> $stable(data_rdata))
        else $error("read data changed with no read");

    a_rst_zero: assert property (
        @(posedge sys_clk)
        !rst_n |-> data_rdata == CMMD_RDATA_RST)
        else $error("read data not cleared in reset");

    // program side
    a_prog_page: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        prog_mem_addr[16] == prog_page && prog_mem_addr[15:0] == prog_addr)
        else $error("program page mapping wrong");
endmodule
`default_nettype wire

// *** sim/cmmd_tgt_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cmmd_tgt_model (
    // clock
    input wire logic sys_clk,
    // target selects and address
    input wire logic ram_sel,
    input wire logic reg_sel,
    input wire logic cmem_sel,
    input wire logic [15:0] tgt_addr,
    // read data, one cycle after select
    output logic [7:0] ram_rdata = 8'h5A,
    output logic [7:0] reg_rdata = 8'h5A,
    output logic [7:0] cmem_rdata = 8'h5A
);
    // idle targets toggle so stale data can never pass as a match
    always @(posedge sys_clk) begin
        ram_rdata <= ram_sel ? tgt_addr[7:0] ^ 8'h11 : ~ram_rdata;
        reg_rdata <= reg_sel ? tgt_addr[7:0] ^ 8'h22 : ~reg_rdata;
        cmem_rdata <= cmem_sel ? tgt_addr[7:0] ^ 8'h33 : ~cmem_rdata;
    end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cmmd_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, prog_rd = 1'b0, prog_page = 1'b0;
    logic data_rd = 1'b0, data_wr = 1'b0, prog_mem_rd;
    logic [15:0] prog_addr = 16'h0000, data_addr = 16'h0000, tgt_addr;
    logic [7:0] data_wdata = 8'h00, data_rdata, tgt_wdata;
    logic [7:0] ram_rdata, reg_rdata, cmem_rdata;
    logic [16:0] prog_mem_addr;
    logic ram_sel, ram_wr, reg_sel, reg_wr, cmem_sel, cmem_wr;
    int err_total = 0, check_count = 0;
    // both edges of every segment, reserved read right after a live one
    logic [15:0] addrs [8] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hBFFF,
        16'hC000, 16'hF3FF, 16'hF400, 16'hFFFF};

    cmmd_decoder i_cmmd_decoder (.sys_clk, .nrst, .prog_rd, .prog_addr,
        .prog_page, .prog_mem_rd, .prog_mem_addr, .data_rd, .data_wr,
        .data_addr, .data_wdata, .data_rdata, .ram_sel, .ram_wr, .ram_rdata,
        .reg_sel, .reg_wr, .reg_rdata, .cmem_sel, .cmem_wr, .cmem_rdata,
        .tgt_addr, .tgt_wdata);
    cmmd_tgt_model i_cmmd_tgt_model (.sys_clk, .ram_sel, .reg_sel,
        .cmem_sel, .tgt_addr, .ram_rdata, .reg_rdata, .cmem_rdata);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic acc(input logic [15:0] a, input logic w);
        logic [2:0] s;
        logic [7:0] e;
        s = a <= 16'h7FFF ? 3'h4 : a <= 16'hBFFF ? 3'h2 :
            a <= 16'hF3FF ? 3'h1 : 3'h0;
        e = s[2] ? a[7:0] ^ 8'h11 : s[1] ? a[7:0] ^ 8'h22 :
            s[0] ? a[7:0] ^ 8'h33 : 8'h00;
        data_addr = a;
        data_wdata = ~a[7:0];
        data_rd = !w;
        data_wr = w;
        #1;
        check({ram_sel, reg_sel, cmem_sel}, s);
        check({ram_wr, reg_wr, cmem_wr}, w ? s : 3'h0);
        check({tgt_addr, tgt_wdata}, {a, ~a[7:0]});
        @(negedge sys_clk);
        data_rd = 1'b0;
        data_wr = 1'b0;
        repeat (2) @(negedge sys_clk);
        if (!w) check(data_rdata, e);
    endtask

    task automatic prog_fetch(input logic p, input logic [15:0] a);
        prog_page = p;
        prog_addr = a;
        prog_rd = 1'b1;
        #1;
        check({prog_mem_rd, prog_mem_addr}, {1'b1, p, a});
        @(negedge sys_clk);
        prog_rd = 1'b0;
        #1;
        check(prog_mem_rd, 1'b0);
        // a full cycle low before the next fetch may raise it again
        @(negedge sys_clk);
    endtask

    // ram then register read on consecutive edges
    task automatic back_to_back;
        data_addr = 16'h1234;
        data_rd = 1'b1;
        @(negedge sys_clk);
        data_addr = 16'h9A56;
        @(negedge sys_clk);
        data_rd = 1'b0;
        check(data_rdata, 8'h25);
        @(negedge sys_clk);
        check(data_rdata, 8'h74);
    endtask

    // writes must leave the last read value (back_to_back) alone
    task automatic write_sweep;
        foreach (addrs[i]) acc(addrs[i], 1'b1);
        check(data_rdata, 8'h74);
    endtask

    task automatic reset_mid;
        acc(16'h0042, 1'b0);
        nrst = 1'b0;
        #1;
        check(data_rdata, CMMD_RDATA_RST);
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(data_rdata, CMMD_RDATA_RST);
        acc(16'hC0A5, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (3) @(negedge sys_clk);
        foreach (addrs[i]) acc(addrs[i], 1'b0);
        back_to_back();
        write_sweep();
        reset_mid();
        prog_fetch(1'b0, 16'hFFFF);
        prog_fetch(1'b1, 16'h0000);
        prog_fetch(1'b1, 16'hFFFF);
        complete_run();
    end

    // whole run is under 100 cycles; the limit allows five times that
    initial begin
        #20000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
